// >>> prtm_timer.sv
// Postscaled 8-bit period timer with synchronised interrupt flag.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - Interrupt flag is raised when postscaler count reaches selected 1:1..1:16 ratio.
// - Interrupt request leaves only while the timer interrupt enable is set.
// - Flag sets on the instruction clock within two cycles, stays until software clears.
// - All-zero prescale and postscale selects give one-to-one ratios.
// - With pin clock, run bit and external reset wait two timer clocks.
// - With instruction clock, run and external reset wait one instruction period.
// - Counter advances per prescaler output (every 2^select timer clocks) while run is 1, holds while 0.
// - On count equal to period, counter returns to zero on the next prescaler output.
module prtm_timer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic timer_clock,
   input wire logic instr_tick,
   input wire logic clk_src_instr,
   input wire logic run_bit,
   input wire logic external_reset_input,
   input wire logic [prtm_pkg::PRE_SEL_W-1:0] prescale_select,
   input wire logic [prtm_pkg::POST_SEL_W-1:0] postscale_select,
   input wire logic [prtm_pkg::CNT_W-1:0] period_value,
   input wire logic timer_irq_enable,
   input wire logic timer_irq_flag_clear,
   output logic [prtm_pkg::CNT_W-1:0] count_value,
   output logic postscaled_pulse,
   output logic timer_irq_flag,
   output logic timer_irq_request
);
   import prtm_pkg::*;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   prtm_sync_if tclk_if ();
   prtm_sync_if ers_if ();
   assign tclk_if.raw = timer_clock;
   assign ers_if.raw = external_reset_input;

   prtm_sync u_tclk_sync (
      .clk(clk),
      .rstn(rstn),
      .port(tclk_if.sync)
   );
   prtm_sync u_ers_sync (
      .clk(clk),
      .rstn(rstn),
      .port(ers_if.sync)
   );

   // ************************************************************
   // Timer clock selection and control pipelines
   // ************************************************************
   logic tclk_lvl_q;
   logic tick;
   logic [PIN_SYNC_STAGES-1:0] run_pipe_q, run_pipe_d, ers_pipe_q, ers_pipe_d;
   logic run_eff;
   logic ers_eff;

   // A timer clock input is a rising edge of the filtered pin or an instruction tick.
   assign tick = clk_src_instr ? instr_tick : (tclk_if.level & ~tclk_lvl_q);

   // Control bits only move on timer clock edges, so the delay is counted in timer clocks.
   always_comb begin
      run_pipe_d = run_pipe_q;
      ers_pipe_d = ers_pipe_q;
      if (tick) begin
         run_pipe_d = {run_pipe_q[0], run_bit};
         ers_pipe_d = {ers_pipe_q[0], ers_if.level};
      end
   end

   // The instruction clock path taps the pipe one stage early.
   assign run_eff = clk_src_instr ? run_pipe_q[0] : run_pipe_q[PIN_SYNC_STAGES-1];
   assign ers_eff = clk_src_instr ? ers_pipe_q[0] : ers_pipe_q[PIN_SYNC_STAGES-1];

   // Registers only.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tclk_lvl_q <= 1'b0;
         run_pipe_q <= PIPE_RST;
         ers_pipe_q <= PIPE_RST;
      end else begin
         tclk_lvl_q <= tclk_if.level;
         run_pipe_q <= run_pipe_d;
         ers_pipe_q <= ers_pipe_d;
      end
   end

   // ************************************************************
   // Prescaler, counter and postscaler
   // ************************************************************
   logic [PRE_W-1:0] pre_q, pre_d, pre_top;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [POST_SEL_W-1:0] post_q, post_d;
   logic post_pulse_d, post_pulse_q;
   logic pre_tick;
   logic match;

   // Ratio is two to the select; select zero gives one-to-one.
   assign pre_top = PRE_W'((8'h01 << prescale_select) - 8'h01);
   assign pre_tick = tick & run_eff & (pre_q == pre_top);
   assign match = pre_tick & (cnt_q == period_value);

   // External reset holds the count at zero; it outranks the run bit.
   always_comb begin
      pre_d = pre_q;
      cnt_d = cnt_q;
      post_d = post_q;
      post_pulse_d = 1'b0;
      if (ers_eff) begin
         pre_d = PRE_RST;
         cnt_d = COUNT_RST;
      end else if (tick && run_eff) begin
         pre_d = (pre_q == pre_top) ? PRE_RST : PRE_W'(pre_q + 7'h01);
         if (match) begin
            cnt_d = COUNT_RST;
         end else if (pre_tick) begin
            cnt_d = CNT_W'(cnt_q + 8'h01);
         end
      end
      if (match && !ers_eff) begin
         if (post_q == postscale_select) begin
            post_d = POST_RST;
            post_pulse_d = 1'b1;
         end else begin
            post_d = POST_SEL_W'(post_q + 4'h1);
         end
      end
   end

   // Registers only.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pre_q <= PRE_RST;
         cnt_q <= COUNT_RST;
         post_q <= POST_RST;
         post_pulse_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         post_q <= post_d;
         post_pulse_q <= post_pulse_d;
      end
   end

   // ************************************************************
   // Interrupt flag on the instruction clock
   // ************************************************************
   logic pend_q, pend_d, flag_q, flag_d, req_q, req_d;

   // Events wait in a pending bit and land on the next instruction tick.
   // A set landing with a software clear wins, so no event is lost.
   always_comb begin
      pend_d = pend_q;
      flag_d = flag_q;
      if (post_pulse_q) begin
         pend_d = 1'b1;
      end else if (instr_tick) begin
         pend_d = 1'b0;
      end
      if (instr_tick && pend_q) begin
         flag_d = 1'b1;
      end else if (timer_irq_flag_clear) begin
         flag_d = 1'b0;
      end
      req_d = flag_d & timer_irq_enable;
   end

   // Registers only.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pend_q <= 1'b0;
         flag_q <= 1'b0;
         req_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         flag_q <= flag_d;
         req_q <= req_d;
      end
   end

   assign count_value = cnt_q;
   assign postscaled_pulse = post_pulse_q;
   assign timer_irq_flag = flag_q;
   assign timer_irq_request = req_q;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_match;
      match && !ers_eff;
   endsequence
   sequence s_tick_run;
      tick && run_eff && !ers_eff && !pre_tick;
   endsequence
   sequence s_pend_land;
      pend_q && instr_tick;
   endsequence

   AST_WRAP_ZERO: assert property (s_match |=> count_value == 8'h00)
      else $error("Counter did not wrap after period match.");
   AST_HOLD_STOPPED: assert property (!run_eff && !ers_eff |=> $stable(count_value))
      else $error("Counter moved while stopped.");
   AST_COUNT_UP: assert property (pre_tick && !match && !ers_eff |=> count_value == $past(cnt_q) + 8'h01)
      else $error("Counter did not advance by one.");
   AST_PRE_HOLD: assert property (s_tick_run |=> $stable(count_value))
      else $error("Counter advanced between prescaler ticks.");
   AST_POST_PULSE: assert property ((s_match and (post_q == postscale_select)) |=> postscaled_pulse && post_q == 4'h0)
      else $error("Postscaler missed its ratio.");
   AST_POST_ADV: assert property ((s_match and (post_q != postscale_select)) |=> !postscaled_pulse)
      else $error("Postscaler pulsed early.");
   AST_MATCH_EQ: assert property (match |-> cnt_q == period_value)
      else $error("Match without equal count.");
   AST_PEND_SET: assert property (postscaled_pulse |=> pend_q)
      else $error("Postscaled pulse did not leave a pending flag event.");
   // A pending event landing on a tick must set the flag even if software clears in that cycle.
   AST_FLAG_SET: assert property (s_pend_land |=> timer_irq_flag)
      else $error("Pending flag event did not land on the instruction tick.");
   AST_FLAG_STICKY: assert property (flag_q && !timer_irq_flag_clear |=> flag_q)
      else $error("Flag dropped without clear.");
   AST_IRQ_GATE: assert property (timer_irq_request |-> $past(timer_irq_enable))
      else $error("Interrupt request left while disabled.");
   AST_RUN_DELAY: assert property (!clk_src_instr && tick |=> run_pipe_q[0] == $past(run_bit))
      else $error("Run bit pipeline not loaded on timer clock.");
   AST_ERS_DELAY: assert property (!clk_src_instr && tick |=> ers_pipe_q[1] == $past(ers_pipe_q[0]))
      else $error("External reset did not take its second timer clock.");
   AST_RUN_INSTR: assert property (clk_src_instr && tick |=> run_eff == $past(run_bit))
      else $error("Run bit did not apply in the next instruction period.");
endmodule
`default_nettype wire

// >>> prtm_pkg.sv
// Shared constants for the postscaled period timer.
package prtm_pkg;
   localparam int CNT_W = 8;
   localparam int PRE_SEL_W = 3;
   localparam int POST_SEL_W = 4;
   localparam int PRE_W = 7;
   localparam int PIN_SYNC_STAGES = 2;
   localparam int INSTR_SYNC_STAGES = 1;
   localparam int FLAG_SYNC_MAX_INSTR = 2;
   localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
   localparam logic [PRE_W-1:0] PRE_RST = 7'h00;
   localparam logic [POST_SEL_W-1:0] POST_RST = 4'h0;
   localparam logic [PIN_SYNC_STAGES-1:0] PIPE_RST = 2'h0;
endpackage

// >>> prtm_sync_if.sv
// Carrier between the pin synchroniser and the timer core.
`timescale 1ns/1ns
`default_nettype none
interface prtm_sync_if;
   logic raw;
   logic level;
   modport sync (input raw, output level);
   modport user (output raw, input level);
endinterface
`default_nettype wire

// >>> prtm_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ns
`default_nettype none
module prtm_sync (
   input wire logic clk,
   input wire logic rstn,
   prtm_sync_if.sync port
);
   logic [2:0] stg_q;
   logic [2:0] stg_d;
   logic lvl_q;
   logic lvl_d;

   // The first stage feeds only the second; the level moves once stages two and three agree.
   always_comb begin
      stg_d = {stg_q[1:0], port.raw};
      lvl_d = (stg_q[1] == stg_q[2]) ? stg_q[2] : lvl_q;
   end

   // Registers only.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stg_q <= 3'h0;
         lvl_q <= 1'b0;
      end else begin
         stg_q <= stg_d;
         lvl_q <= lvl_d;
      end
   end

   assign port.level = lvl_q;
endmodule
`default_nettype wire

// >>> prtm_timer_tb_top.sv
// Self-checking random testbench for the postscaled period timer.
`timescale 1ns/1ns
`default_nettype none
module prtm_timer_tb_top;
   import prtm_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic timer_clock = 1'b0;
   logic instr_tick = 1'b0;
   logic clk_src_instr = 1'b1;
   logic run_bit = 1'b0;
   logic external_reset_input = 1'b0;
   logic [PRE_SEL_W-1:0] prescale_select = 3'h0;
   logic [POST_SEL_W-1:0] postscale_select = 4'h0;
   logic [CNT_W-1:0] period_value = 8'h00;
   logic timer_irq_enable = 1'b0;
   logic timer_irq_flag_clear = 1'b0;
   logic [CNT_W-1:0] count_value;
   logic postscaled_pulse;
   logic timer_irq_flag;
   logic timer_irq_request;
   int n_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   bit pin_en = 1'b0;

   // ****************************************
   // Clock, instruction tick, pin clock and timeout.
   // ****************************************
   always #2 clk = ~clk;

   // Ticks every 4 clocks; the pin clock is 5 high and 5 low, slow enough for the filter.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      instr_tick <= #1 (cycles % 4 == 3);
      timer_clock <= #1 pin_en && (cycles % 10 >= 5);
      if (cycles == 100000) begin
         n_errors++;
         end_sim();
      end
   end

   prtm_timer i_dut (.clk(clk), .rstn(rstn), .timer_clock(timer_clock), .instr_tick(instr_tick),
      .clk_src_instr(clk_src_instr), .run_bit(run_bit), .external_reset_input(external_reset_input),
      .prescale_select(prescale_select), .postscale_select(postscale_select),
      .period_value(period_value), .timer_irq_enable(timer_irq_enable),
      .timer_irq_flag_clear(timer_irq_flag_clear), .count_value(count_value),
      .postscaled_pulse(postscaled_pulse), .timer_irq_flag(timer_irq_flag),
      .timer_irq_request(timer_irq_request));

   // ****************************************
   // Shared tasks.
   // ****************************************
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Counts clocks up to the next pulse; the count must never pass the period meanwhile.
   task automatic wait_pulse(output int n);
      n = 0;
      do begin
         step(1);
         n++;
         if ($isunknown(count_value) || count_value > period_value) chk(32'(count_value), 32'(period_value));
      end while (postscaled_pulse !== 1'b1 && n < 20000);
      if (postscaled_pulse !== 1'b1) chk(32'(postscaled_pulse), 32'h1);
   endtask

   // The first interval after a restart is partial because the postscaler survives reset.
   task automatic run_case(input int pre, input int post, input int per, input int tp);
      int n;
      prescale_select = pre[2:0];
      postscale_select = post[3:0];
      period_value = per[7:0];
      external_reset_input = 1'b1;
      run_bit = 1'b1;
      step(30);
      external_reset_input = 1'b0;
      wait_pulse(n);
      wait_pulse(n);
      chk(n, (per + 1) * (1 << pre) * (post + 1) * tp);
      $display("case pre=%0d post=%0d per=%0d done", pre, post, per);
   endtask

   // Stops the timer so no pending flag can sneak in, then checks set, hold and clear.
   task automatic flag_test(input logic en);
      int n;
      logic [CNT_W-1:0] held;
      run_bit = 1'b0;
      timer_irq_enable = en;
      step(20);
      timer_irq_flag_clear = 1'b1;
      step(1);
      timer_irq_flag_clear = 1'b0;
      run_bit = 1'b1;
      wait_pulse(n);
      run_bit = 1'b0;
      n = 0;
      while (timer_irq_flag !== 1'b1 && n < 9) begin
         step(1);
         n++;
      end
      chk(32'(timer_irq_flag), 32'h1);
      step(1);
      chk(32'(timer_irq_request), 32'(en));
      step(12);
      held = count_value;
      step(40);
      chk(32'(count_value), 32'(held));
      chk(32'(timer_irq_flag), 32'h1);
      timer_irq_flag_clear = 1'b1;
      step(1);
      timer_irq_flag_clear = 1'b0;
      step(1);
      chk(32'(timer_irq_flag), 32'h0);
      chk(32'(timer_irq_request), 32'h0);
      $display("flag test en=%0d done", en);
   endtask

   task automatic end_sim();
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      void'($urandom(32'h3a98));
      step(8);
      rstn = 1'b1;
      for (int i = 0; i < 16; i++) run_case(0, i, 0, 4);
      for (int i = 0; i < 8; i++) run_case(i, 0, 1, 4);
      repeat (8) run_case($urandom % 3, $urandom % 8, $urandom % 16, 4);
      run_case(0, 0, 20, 4);
      flag_test(1'b1);
      flag_test(1'b0);
      clk_src_instr = 1'b0;
      pin_en = 1'b1;
      run_case(0, 1, 3, 10);
      end_sim();
   end
endmodule
`default_nettype wire
